/* File: src/refresh_defines.svh */
/*
   Timing, mode-register codes and offsets for both ends.
   Assumes a 100 MHz clock; included by the package file.
*/
`ifndef REFRESH_DEFINES_SVH
`define REFRESH_DEFINES_SVH
`define CLK_PERIOD_NS 10
`define REFI_BASE_NS  7800
`define REFI_BASE_CYC (`REFI_BASE_NS / `CLK_PERIOD_NS)
`define RFC_1X_NS     260
`define RFC_2X_NS     160
`define RFC_4X_NS     110
`define RFC_1X_CYC    ((`RFC_1X_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RFC_2X_CYC    ((`RFC_2X_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RFC_4X_CYC    ((`RFC_4X_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MRS_GAP_CYC   8
`define MR3_SEL       3'h3
`define MR4_SEL       3'h4
`define RATE_LSB      6
`define TCR_EN_BIT    2
`define TCR_EXT_BIT   3
`define TEMP_COOL_C   8'h2D
`define TEMP_HOT_C    8'h55
`define RATE_FIX1     3'h0
`define RATE_FIX2     3'h1
`define RATE_FIX4     3'h2
`define RATE_OTF12    3'h5
`define RATE_OTF14    3'h6
`define OFS_CTRL      4'h0
`define OFS_CMD       4'h4
`define OFS_STAT      4'h8
`define CTRL_AUTO     0
`define CTRL_RATE_LSB 1
`define CTRL_TCR      4
`define CTRL_EXT      5
`define CTRL_HOT      6
`define CTRL_HIGH     7
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

/* File: src/refresh_pkg.sv */
/*
   Types and decode functions shared by both ends.
   Assumes refresh_defines.svh is on the include path.
*/
`include "refresh_defines.svh"
package refresh_pkg;
   // Kind of one refresh, one-hot.
   typedef enum logic [2:0] {KIND_1X = 3'h1, KIND_2X = 3'h2, KIND_4X = 3'h4} kind_type;
   // Controller sequencer states, one-hot.
   typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_MR4 = 3'h2, ST_WAIT = 3'h4} state_type;

   // Rate chosen by the field and, in the on-the-fly pairs, by bank-group bit 0.
   function automatic kind_type kind_of(input logic [2:0] field, input logic bg0);
      kind_type k;
      k = KIND_1X;
      case (field)
         `RATE_FIX2:  k = KIND_2X;
         `RATE_FIX4:  k = KIND_4X;
         `RATE_OTF12: k = bg0 ? KIND_2X : KIND_1X;
         `RATE_OTF14: k = bg0 ? KIND_4X : KIND_1X;
         default:     k = KIND_1X;
      endcase
      return k;
   endfunction

   // Cycle time of a refresh of the given kind, in clock cycles.
   function automatic logic [9:0] rfc_of(input kind_type k);
      logic [9:0] c;
      c = 10'(`RFC_1X_CYC);
      if (k == KIND_2X) c = 10'(`RFC_2X_CYC);
      if (k == KIND_4X) c = 10'(`RFC_4X_CYC);
      return c;
   endfunction
endpackage

/* File: src/refresh_link_if.sv */
/*
   Command bus between the memory controller and the device, one modport per end.
   Assumes both ends share one clock; the bench instantiates it and joins the ends.
*/
`timescale 1ns/1ns
`default_nettype none
interface refresh_link_if;
   logic        cs_n;   // Chip select, active low.
   logic        act_n;  // Activate, active low.
   logic        ras_n;  // Row strobe, active low.
   logic        cas_n;  // Column strobe, active low.
   logic        we_n;   // Write enable, active low.
   logic        bg0;    // Bank-group bit 0, rate pick in on-the-fly modes.
   logic [2:0]  mr_sel; // Mode register number during a mode write.
   logic [13:0] addr;   // Address bits, mode data during a mode write.

   modport device (input cs_n, act_n, ras_n, cas_n, we_n, bg0, mr_sel, addr);
   modport ctrl   (output cs_n, act_n, ras_n, cas_n, we_n, bg0, mr_sel, addr);
endinterface
`default_nettype wire

/* File: src/cycle_timer.sv */
/*
   Down counter, busy for a loaded number of cycles.
   Assumes load comes from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cycle_timer (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       load,
   input  wire logic [9:0] count,
   output logic            busy
);
   logic [9:0] count_r;   // Cycles left.
   logic [9:0] count_nxt; // Next value of the count.

   // A load restarts the count; otherwise it runs down to zero and stops.
   always_comb begin
      count_nxt = count_r;
      if (load) begin
         count_nxt = count;
      end else if (count_r != 10'h000) begin
         count_nxt = count_r - 10'h001;
      end
   end

   // Register only.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_r <= 10'h000;
      end else begin
         count_r <= count_nxt;
      end
   end

   // Busy for exactly count cycles after the load edge.
   assign busy = (count_r != 10'h000);
endmodule // cycle_timer
`default_nettype wire

/* File: src/refresh_device.sv */
/*
   Device end: decodes refresh and mode writes, holds rate and temperature
   settings, gears internal refreshes and times each one.
   Assumes commands come on clk; case_temp comes from another domain, changes slowly.
*/
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Normal range: refresh every 7.8us, max 85C.
// - Below 45C skip some refreshes in normal range.
// - Extended range: refresh every 3.9us, to 95C.
// - Extended range: gear to 7.8us below 85C.
// - Extended range forbids a 7.8us external period.
// - Mode write sets fixed or on-the-fly rate.
// - Enable on-the-fly before any on-the-fly refresh.
// - Field codes 000,001,010,101,110; others reserved.
// - On-the-fly: bank-group bit 0 picks the rate.
// - Refresh decode: cs,ras,cas low; act,we high.
// - Reset gives fixed 1x rate.
// - 2x mode halves, 4x quarters the interval.
// - Each mode permits only its own refresh kinds.
// - Base interval 7.8us, halved above 85C.
// - Cycle times 260, 160, 110 ns per kind.
// - Only deselects until the cycle time passes.
// - Temperature refresh only with fixed 1x.
module refresh_device (
   input  wire logic       clk,
   input  wire logic       resetn,
   refresh_link_if.device  link,
   input  wire logic [7:0] case_temp,
   output logic            refresh_strobe,
   output logic [2:0]      refresh_kind,
   output logic            internal_refresh,
   output logic            refresh_busy,
   output logic [2:0]      rate_field,
   output logic            tcr_enable,
   output logic            tcr_extended,
   output logic            reserved_code,
   output logic            protocol_error
);
   // Settings held from mode writes.
   logic [2:0] field_r;     // Refresh rate field.
   logic [2:0] field_nxt;   // Next field.
   logic       tcr_en_r;    // Temperature-controlled refresh on.
   logic       tcr_en_nxt;  // Next enable.
   logic       tcr_ext_r;   // Extended range selected.
   logic       tcr_ext_nxt; // Next range.

   // Temperature synchroniser.
   logic [7:0] temp_meta_r; // First stage, read only by the second.
   logic [7:0] temp_sync_r; // Second stage, safe to use.

   // Refresh bookkeeping.
   logic [1:0] gear_r;      // Counts external refreshes for skipping.
   logic [1:0] gear_nxt;    // Next gear count.
   logic [2:0] kind_r;      // Kind of the last refresh.
   logic [2:0] kind_nxt;    // Next kind.
   logic       strobe_r;    // Refresh decoded last cycle.
   logic       strobe_nxt;  // Next strobe.
   logic       exec_r;      // Internal refresh run last cycle.
   logic       exec_nxt;    // Next internal pulse.
   logic       err_r;       // Protocol error last cycle.
   logic       err_nxt;     // Next error.

   // Decode helpers.
   logic                 is_cmd;   // Shared refresh and mode-write pattern.
   logic                 is_ref;   // Refresh at this edge.
   logic                 is_mrs;   // Mode write at this edge.
   logic                 reserved; // Field holds a reserved code.
   logic [1:0]           mask;     // Gear bits that must be zero to run.
   logic                 busy;     // Refresh cycle time running.
   refresh_pkg::kind_type kind_now; // Kind of the refresh at this edge.

   // Refresh and mode write share all strobes but write enable.
   assign is_cmd = !link.cs_n && link.act_n && !link.ras_n && !link.cas_n;
   assign is_ref = is_cmd && link.we_n;
   assign is_mrs = is_cmd && !link.we_n;

   // Bank-group bit 0 counts only in the on-the-fly pairs.
   assign kind_now = refresh_pkg::kind_of(field_r, link.bg0);

   // Codes outside the five legal ones are flagged reserved.
   always_comb begin
      unique case (field_r)
         `RATE_FIX1, `RATE_FIX2, `RATE_FIX4, `RATE_OTF12, `RATE_OTF14: begin
            reserved = 1'b0;
         end
         default: begin
            reserved = 1'b1;
         end
      endcase
   end

   // Skip ratio from enable, range and temperature; only in fixed 1x, the
   // one rate the temperature mode allows.
   always_comb begin
      mask = 2'h0;
      if (tcr_en_r && field_r == `RATE_FIX1) begin
         if (tcr_ext_r) begin
            // Extended range: 3.9us external period geared down.
            if (temp_sync_r < `TEMP_COOL_C) begin
               mask = 2'h3;
            end else if (temp_sync_r < `TEMP_HOT_C) begin
               mask = 2'h1;
            end else begin
               mask = 2'h0;
            end
         end else if (temp_sync_r < `TEMP_COOL_C) begin
            // Normal range: cool parts stretch the period further.
            mask = 2'h1;
         end
      end
   end

   // Mode writes to the two registers this block owns.
   always_comb begin
      field_nxt   = field_r;
      tcr_en_nxt  = tcr_en_r;
      tcr_ext_nxt = tcr_ext_r;
      if (is_mrs && link.mr_sel == `MR3_SEL) begin
         // Reserved codes are stored, to be seen read back.
         field_nxt = link.addr[`RATE_LSB+2:`RATE_LSB];
      end
      if (is_mrs && link.mr_sel == `MR4_SEL) begin
         tcr_en_nxt  = link.addr[`TCR_EN_BIT];
         tcr_ext_nxt = link.addr[`TCR_EXT_BIT];
      end
   end

   // Per refresh: kind, gearing and the internal pulse.
   always_comb begin
      gear_nxt   = gear_r;
      kind_nxt   = kind_r;
      strobe_nxt = is_ref;
      exec_nxt   = 1'b0;
      if (is_ref) begin
         kind_nxt = kind_now;
         gear_nxt = gear_r + 2'h1;
         // A skipped refresh still occupies the bus for its cycle time.
         exec_nxt = ((gear_r & mask) == 2'h0);
      end
      // Anything but a deselect during the cycle time, or a refresh under a
      // reserved code, is reported; the device cannot refuse the command.
      err_nxt = (busy && !link.cs_n) || (is_ref && reserved);
   end

   // Cycle time of each refresh, from the kind it was decoded as.
   cycle_timer rfc_timer (
      .clk    (clk),
      .resetn (resetn),
      .load   (is_ref),
      .count  (refresh_pkg::rfc_of(kind_now)),
      .busy   (busy)
   );

   // Settings; reset leaves fixed 1x, temperature refresh off.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         field_r   <= `RATE_FIX1;
         tcr_en_r  <= 1'b0;
         tcr_ext_r <= 1'b0;
      end else begin
         field_r   <= field_nxt;
         tcr_en_r  <= tcr_en_nxt;
         tcr_ext_r <= tcr_ext_nxt;
      end
   end

   // Two-stage synchroniser for the temperature reading. A multi-bit value can
   // tear for a cycle; temperature moves far slower than that, so it is harmless.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         temp_meta_r <= 8'h00;
         temp_sync_r <= 8'h00;
      end else begin
         temp_meta_r <= case_temp;
         temp_sync_r <= temp_meta_r;
      end
   end

   // Bookkeeping registers.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gear_r   <= 2'h0;
         kind_r   <= refresh_pkg::KIND_1X;
         strobe_r <= 1'b0;
         exec_r   <= 1'b0;
         err_r    <= 1'b0;
      end else begin
         gear_r   <= gear_nxt;
         kind_r   <= kind_nxt;
         strobe_r <= strobe_nxt;
         exec_r   <= exec_nxt;
         err_r    <= err_nxt;
      end
   end

   // Outputs come from flip-flops, except refresh_busy and reserved_code, which are decoded from registers.
   assign refresh_strobe   = strobe_r;
   assign refresh_kind     = kind_r;
   assign internal_refresh = exec_r;
   assign refresh_busy     = busy;
   assign rate_field       = field_r;
   assign tcr_enable       = tcr_en_r;
   assign tcr_extended     = tcr_ext_r;
   assign reserved_code    = reserved;
   assign protocol_error   = err_r;
endmodule // refresh_device
`default_nettype wire

/* File: src/refresh_ctrl.sv */
/*
   Controller end: AXI4-Lite slave, mode programming, periodic refresh.
   Assumes the device's clock and a well-behaved master.
*/
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module refresh_ctrl (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   refresh_link_if.ctrl     link
);
   // Bus slave state.
   logic aw_full_r, aw_full_nxt; // Write address held.
   logic [3:0] aw_addr_r, aw_addr_nxt;
   logic w_full_r, w_full_nxt;   // Write data held.
   logic [7:0] w_data_r, w_data_nxt;
   logic w_lane_r, w_lane_nxt;   // Low byte lane enabled.
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;

   // Software settings and programmed state.
   logic [7:0] ctrl_r, ctrl_nxt;        // Control register.
   logic prog_req_r, prog_req_nxt;      // Mode programming pending.
   logic [2:0] field_r, field_nxt;      // Field last written to the device.
   logic ext_r, ext_nxt;                // Extended range programmed.
   logic tcr_r, tcr_nxt;                // Temperature refresh requested.
   refresh_pkg::state_type state_r, state_nxt;
   logic [9:0] refi_r, refi_nxt;        // Cycles to the next refresh.
   logic [7:0] refs_r, refs_nxt;        // Refreshes issued.

   // Command outputs, one cycle each.
   logic cs_n_r, cs_n_nxt, we_n_r, we_n_nxt, bg0_r, bg0_nxt;
   logic [2:0] sel_r, sel_nxt;
   logic [13:0] addr_r, addr_nxt;

   logic do_wr, mapped, t_load, busy, on_the_fly_rate, halve;
   logic [9:0] t_count;
   logic [1:0] shift;
   refresh_pkg::kind_type kind;

   assign awready = !aw_full_r && !bvalid_r;
   assign wready  = !w_full_r && !bvalid_r;
   assign arready = !rvalid_r;
   assign do_wr   = aw_full_r && w_full_r;
   assign mapped  = (aw_addr_r == `OFS_CTRL) || (aw_addr_r == `OFS_CMD);

   // Bus slave: address and data latched in any order, written together.
   always_comb begin
      aw_full_nxt = aw_full_r;
      aw_addr_nxt = aw_addr_r;
      w_full_nxt  = w_full_r;
      w_data_nxt  = w_data_r;
      w_lane_nxt  = w_lane_r;
      bvalid_nxt  = bvalid_r && !bready;
      bresp_nxt   = bresp_r;
      rvalid_nxt  = rvalid_r && !rready;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      if (awvalid && awready) begin
         aw_full_nxt = 1'b1;
         aw_addr_nxt = awaddr;
      end
      if (wvalid && wready) begin
         w_full_nxt = 1'b1;
         w_data_nxt = wdata[7:0];
         w_lane_nxt = wstrb[0];
      end
      if (do_wr) begin
         aw_full_nxt = 1'b0;
         w_full_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (arvalid && arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = `RESP_OKAY;
         unique case (araddr)
            `OFS_CTRL: rdata_nxt = {24'h000000, ctrl_r};
            `OFS_CMD:  rdata_nxt = 32'h00000000;
            `OFS_STAT: rdata_nxt = {16'h0000, refs_r, 3'h0, prog_req_r, field_r,
                                    state_r != refresh_pkg::ST_IDLE};
            default: begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = `RESP_SLVERR;
            end
         endcase
      end
   end

   // Refresh kind from the field the device holds, never the unsent one.
   assign on_the_fly_rate   = field_r[2];
   assign kind  = refresh_pkg::kind_of(field_r, on_the_fly_rate && ctrl_r[`CTRL_HIGH]);
   assign halve = ext_r || ctrl_r[`CTRL_HOT];

   // Sequencer: program mode registers, then issue periodic refreshes.
   always_comb begin
      ctrl_nxt  = ctrl_r;
      field_nxt = field_r;
      ext_nxt   = ext_r;
      tcr_nxt   = tcr_r;
      state_nxt = state_r;
      refs_nxt  = refs_r;
      refi_nxt  = (refi_r != 10'h000) ? refi_r - 10'h001 : refi_r;
      cs_n_nxt  = 1'b1;
      we_n_nxt  = 1'b1;
      bg0_nxt   = 1'b0;
      sel_nxt   = 3'h0;
      addr_nxt  = 14'h0000;
      t_load    = 1'b0;
      t_count   = 10'(`MRS_GAP_CYC);
      shift     = 2'h0;
      if (kind == refresh_pkg::KIND_2X) shift = 2'h1;
      if (kind == refresh_pkg::KIND_4X) shift = 2'h2;
      if (do_wr && mapped && aw_addr_r == `OFS_CTRL && w_lane_r) ctrl_nxt = w_data_r;
      // Set wins: a request in the cycle it is taken is kept.
      prog_req_nxt = prog_req_r || (do_wr && aw_addr_r == `OFS_CMD && w_lane_r && w_data_r[0]);
      unique case (state_r)
         refresh_pkg::ST_IDLE: begin
            if (prog_req_r) begin
               cs_n_nxt  = 1'b0;
               we_n_nxt  = 1'b0;
               sel_nxt   = `MR3_SEL;
               addr_nxt[`RATE_LSB+2:`RATE_LSB] = ctrl_r[`CTRL_RATE_LSB+2:`CTRL_RATE_LSB];
               field_nxt = ctrl_r[`CTRL_RATE_LSB+2:`CTRL_RATE_LSB];
               ext_nxt   = ctrl_r[`CTRL_EXT];
               tcr_nxt   = ctrl_r[`CTRL_TCR];
               prog_req_nxt = (do_wr && aw_addr_r == `OFS_CMD && w_lane_r && w_data_r[0]);
               state_nxt = refresh_pkg::ST_MR4;
            end else if (ctrl_r[`CTRL_AUTO] && refi_r == 10'h000) begin
               cs_n_nxt  = 1'b0;
               bg0_nxt   = on_the_fly_rate && ctrl_r[`CTRL_HIGH];
               t_load    = 1'b1;
               t_count   = refresh_pkg::rfc_of(kind);
               // Reload one short, since the refresh cycle itself counts.
               refi_nxt  = (10'(`REFI_BASE_CYC) >> (shift + {1'b0, halve})) - 10'h001;
               refs_nxt  = refs_r + 8'h01;
               state_nxt = refresh_pkg::ST_WAIT;
            end
         end
         refresh_pkg::ST_MR4: begin
            cs_n_nxt = 1'b0;
            we_n_nxt = 1'b0;
            sel_nxt  = `MR4_SEL;
            addr_nxt[`TCR_EN_BIT]  = tcr_r && (field_r == `RATE_FIX1);
            addr_nxt[`TCR_EXT_BIT] = ext_r;
            t_load    = 1'b1;
            state_nxt = refresh_pkg::ST_WAIT;
         end
         refresh_pkg::ST_WAIT: begin
            // Deselects until the timer runs out.
            if (!busy) state_nxt = refresh_pkg::ST_IDLE;
         end
      endcase
   end

   cycle_timer gap_timer (
      .clk    (clk),
      .resetn (resetn),
      .load   (t_load),
      .count  (t_count),
      .busy   (busy)
   );

   // Register only.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         aw_full_r <= 1'b0; aw_addr_r <= 4'h0; w_full_r <= 1'b0; w_data_r <= 8'h00;
         w_lane_r <= 1'b0; bvalid_r <= 1'b0; bresp_r <= 2'h0; rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000; rresp_r <= 2'h0; ctrl_r <= 8'h00;
         prog_req_r <= 1'b0; field_r <= `RATE_FIX1; ext_r <= 1'b0; tcr_r <= 1'b0;
         state_r <= refresh_pkg::ST_IDLE; refi_r <= 10'h000; refs_r <= 8'h00;
         cs_n_r <= 1'b1; we_n_r <= 1'b1; bg0_r <= 1'b0; sel_r <= 3'h0;
         addr_r <= 14'h0000;
      end else begin
         aw_full_r <= aw_full_nxt; aw_addr_r <= aw_addr_nxt; w_full_r <= w_full_nxt;
         w_data_r <= w_data_nxt; w_lane_r <= w_lane_nxt; bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt; rvalid_r <= rvalid_nxt; rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt; ctrl_r <= ctrl_nxt; prog_req_r <= prog_req_nxt;
         field_r <= field_nxt; ext_r <= ext_nxt; tcr_r <= tcr_nxt;
         state_r <= state_nxt; refi_r <= refi_nxt; refs_r <= refs_nxt;
         cs_n_r <= cs_n_nxt; we_n_r <= we_n_nxt; bg0_r <= bg0_nxt; sel_r <= sel_nxt;
         addr_r <= addr_nxt;
      end
   end

   assign bvalid      = bvalid_r;
   assign bresp       = bresp_r;
   assign rvalid      = rvalid_r;
   assign rdata       = rdata_r;
   assign rresp       = rresp_r;
   assign link.cs_n   = cs_n_r;
   assign link.act_n  = 1'b1;
   assign link.ras_n  = cs_n_r;
   assign link.cas_n  = cs_n_r;
   assign link.we_n   = we_n_r;
   assign link.bg0    = bg0_r;
   assign link.mr_sel = sel_r;
   assign link.addr   = addr_r;
endmodule // refresh_ctrl
`default_nettype wire

/* File: tb/refresh_link_sva.sv */
/* Checker for the refresh command bus.
   Assumes one clock; takes the link signals as inputs. */
`timescale 1ns/1ns
`default_nettype none
module refresh_link_sva (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        cs_n,
   input wire logic        act_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic        bg0,
   input wire logic [2:0]  mr_sel,
   input wire logic [13:0] addr
);
   logic       rf, m3, m4;       // Refresh and mode writes seen this cycle.
   logic [9:0] gap_r, gap_nxt;   // Cycles since the last refresh, saturating.
   logic [9:0] need_r, need_nxt; // Cycle time owed to the last refresh.
   logic [2:0] fld_r, fld_nxt;   // Rate field last written to the device.
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Tracks the field, so spacing follows the kind.
   always_comb begin
      rf = !cs_n && we_n;
      m3 = !cs_n && !we_n && mr_sel == 3'h3;
      m4 = !cs_n && !we_n && mr_sel == 3'h4;
      fld_nxt = m3 ? addr[8:6] : fld_r;
      gap_nxt = rf ? 10'h001 : gap_r + 10'(gap_r != 10'h3FF);
      need_nxt = need_r;
      if (rf) need_nxt = (fld_r == 3'h1 || fld_r == 3'h5 && bg0) ? 10'h010 :
         (fld_r == 3'h2 || fld_r == 3'h6 && bg0) ? 10'h00B : 10'h01A;
   end
   // Starts saturated so the first command after reset is never flagged.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gap_r <= 10'h3FF;
         need_r <= 10'h000;
         fld_r <= 3'h0;
      end else begin
         gap_r <= gap_nxt;
         need_r <= need_nxt;
         fld_r <= fld_nxt;
      end
   end
   AST_ACT: assert property (act_n) else $error("act_n driven low");
   AST_STROBES: assert property (ras_n == cs_n && cas_n == cs_n)
      else $error("row or column strobe differs from select");
   AST_RFC: assert property (!cs_n |-> gap_r >= need_r)
      else $error("command inside refresh cycle time");
   AST_BG0: assert property (rf && !fld_r[2] |-> !bg0)
      else $error("rate pick high outside on-the-fly mode");
   AST_MR4_NEXT: assert property (m3 |=> m4) else $error("no MR4 after MR3");
   AST_MR3_FIRST: assert property (m4 |-> $past(m3)) else $error("MR4 alone");
   AST_MRS_GAP: assert property (m4 |=> cs_n [*8]) else $error("mode gap short");
   AST_TCR_FIX1: assert property (m4 && addr[2] |-> fld_r == 3'h0)
      else $error("temperature refresh with non-1x field");
endmodule // refresh_link_sva
`default_nettype wire

/* File: tb/dram_refresh_rate_modes_test.sv */
/* Bench joining controller and device over the link.
   Assumes the design sources are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`include "refresh_defines.svh"
module dram_refresh_rate_modes_test;
   logic clk = 1'h0, resetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, q;
   logic [1:0] bresp, rresp, rs;
   logic [7:0] case_temp = 8'h00, c;
   logic strobe, intref, busy, tcr_en, tcr_ext, resv, perr;
   logic [2:0] kind, field;
   logic [2:0] modes [8] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h3, 3'h4, 3'h7};
   logic ext [5] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0};
   int tlo [5] = '{0, 0, 45, 85, 45}, thi [5] = '{44, 44, 84, 95, 84};
   int iexp [5] = '{2, 1, 2, 4, 4}, err_total = 0, check_count = 0, gap, ints, cyc = 0, last;
   refresh_link_if link ();
   refresh_ctrl u_refresh_ctrl (.clk(clk), .resetn(resetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .link(link));
   refresh_device u_refresh_device (.clk(clk), .resetn(resetn), .link(link),
      .case_temp(case_temp), .refresh_strobe(strobe), .refresh_kind(kind),
      .internal_refresh(intref), .refresh_busy(busy), .rate_field(field),
      .tcr_enable(tcr_en), .tcr_extended(tcr_ext), .reserved_code(resv),
      .protocol_error(perr));
   refresh_link_sva u_refresh_link_sva (.clk(clk), .resetn(resetn), .cs_n(link.cs_n),
      .act_n(link.act_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
      .bg0(link.bg0), .mr_sel(link.mr_sel), .addr(link.addr));
   initial forever #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (err_total == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // One AXI4-Lite write or read.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      logic ta, tw, tr, td;
      @(posedge clk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      forever begin
         @(negedge clk);
         ta = awready;
         tw = wready;
         tr = arready;
         td = w ? bvalid : rvalid;
         q = rdata;
         rs = w ? bresp : rresp;
         @(posedge clk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         if (tr) arvalid <= 1'h0;
         if (td === 1'h1) break;
      end
      bready <= 1'h0;
      rready <= 1'h0;
   endtask
   task automatic wait_ref();
      int t;
      t = 0;
      do begin
         @(negedge clk);
         t++;
      end while (strobe !== 1'h1 && t < 2000);
      gap = cyc - last;
      last = cyc;
   endtask
   // One old-mode refresh, and one still at the old spacing, may come.
   task automatic prog(input logic [7:0] v);
      bus(1'h1, `OFS_CTRL, {24'h0, v});
      bus(1'h1, `OFS_CMD, 32'h1);
      repeat (2) wait_ref();
   endtask
   function automatic logic [2:0] kexp(input logic [2:0] f, input logic h);
      return (f == 3'h1 || f == 3'h5 && h) ? 3'h2 : (f == 3'h2 || f == 3'h6 && h) ? 3'h4 : 3'h1;
   endfunction
   task automatic ref_one(input logic [2:0] k, input logic h);
      int n;
      wait_ref();
      chk(kind, k);
      chk(perr, resv);
      chk(gap <= (32'h30C >> ({k[2], k[1]} + h)), 32'h1);
      ints += (intref === 1'h1);
      n = 0;
      while (busy === 1'h1 && n < 40) begin
         n++;
         @(negedge clk);
      end
      chk(n, k[0] ? 32'h1A : k[1] ? 32'h10 : 32'h0B);
   endtask
   initial begin
      repeat (80000) @(posedge clk);
      err_total++;
      report_and_stop();
   end
   initial begin
      void'($urandom(62502));
      repeat (2) @(posedge clk);
      resetn <= 1'h1;
      @(negedge clk);
      chk(field, 3'h0);
      chk(tcr_en, 1'h0);
      bus(1'h0, 4'hC, 32'h0);
      chk(rs, `RESP_SLVERR);
      chk(q, 32'h0);
      foreach (modes[i]) begin
         c = 8'($urandom);
         c[3:0] = {modes[i], 1'h1};
         c[5] = 1'h0;
         prog(c);
         bus(1'h0, `OFS_CTRL, 32'h0);
         chk(q[3:0], c[3:0]);
         chk(field, modes[i]);
         chk(resv, modes[i] inside {3'h3, 3'h4, 3'h7});
         chk(tcr_en, c[4] && modes[i] == 3'h0);
         repeat (2) ref_one(kexp(modes[i], c[7]), c[6]);
      end
      foreach (iexp[i]) begin
         @(posedge clk);
         case_temp <= 8'($urandom_range(thi[i], tlo[i]));
         prog({1'h0, ext[i], ext[i], 1'h1, 3'h0, 1'h1});
         chk(tcr_ext, ext[i]);
         ints = 0;
         repeat (4) ref_one(3'h1, ext[i]);
         chk(ints, iexp[i]);
      end
      report_and_stop();
   end
endmodule // dram_refresh_rate_modes_test
`default_nettype wire
